// *** src/fapi_defines.svh ***
`ifndef FAPI_DEFINES_SVH
`define FAPI_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define FAPI_IDX_LPNP        12'hC08
`define FAPI_IDX_CTRL0       12'hC10
`define FAPI_IDX_INT_EN      12'hC18
`define FAPI_IDX_INT_STS     12'hC19

////////////////////////////////////////////////////////////////////////////////
// partner next-page word fields
`define FAPI_NP_MORE_BIT     15
`define FAPI_NP_ACK_BIT      14
`define FAPI_NP_MSG_BIT      13
`define FAPI_NP_COMPLY_BIT   12
`define FAPI_NP_TOGGLE_BIT   11
`define FAPI_NP_CODE_MSB     10
`define FAPI_NP_CODE_LSB     0

// fiber control zero
`define FAPI_CTRL0_BYPASS_BIT 9

// interrupt source bits, same layout in enable and status
`define FAPI_NSRC            10
`define FAPI_BIT_FEF         9
`define FAPI_BIT_TXFULL      8
`define FAPI_BIT_TXEMPTY     7
`define FAPI_BIT_RXFULL      6
`define FAPI_BIT_RXEMPTY     5
`define FAPI_BIT_LINK        4
`define FAPI_BIT_RFAULT      3
`define FAPI_BIT_RESFAIL     2
`define FAPI_BIT_NPRX        1
`define FAPI_BIT_BPRX        0

////////////////////////////////////////////////////////////////////////////////
// reset values
`define FAPI_RST_LPNP        16'h0000
`define FAPI_RST_CTRL0       16'h0000
`define FAPI_RST_INT_EN      16'h03FF
`define FAPI_RST_INT_EN_FLD  10'h3FF
`define FAPI_RST_INT_STS     16'h0000

// bus constants
`define FAPI_HSIZE_WORD      3'h2
`define FAPI_HRESP_OKAY      1'h0

`endif

// *** src/fapi_pkg.sv ***
`default_nettype none
`include "fapi_defines.svh"

package fapi_pkg;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } fapi_sync_state_t;

  typedef struct packed {
    logic                   bypass;
    logic [`FAPI_NSRC-1:0]  irq_en;
    logic [`FAPI_NSRC-1:0]  pend;
    logic [15:0]            np_word;
    logic [5:0]             lvl_prev;
    logic                   armed;
    logic                   busy;
    logic                   op_write;
    logic                   op_read;
    logic                   op_hit;
    logic [11:0]            op_idx;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   resp;
    logic                   irq;
    logic                   sig_det;
  } fapi_state_t;

endpackage : fapi_pkg

`default_nettype wire

// *** src/fapi_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module fapi_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic async_in,
  output logic      sync_out
);
  import fapi_pkg::*;

  fapi_sync_state_t q;
  fapi_sync_state_t next_q;

  // stage1 feeds stage2 only
  always_comb begin
    next_q        = q;
    next_q.stage1 = async_in;
    next_q.stage2 = q.stage1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.stage2;

endmodule : fapi_sync

`default_nettype wire

// *** src/fapi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fapi_defines.svh"

// How it works
// R1: next-page bit 15 shows partner has more pages to send.
// R2: next-page bit 13 shows message page versus unformatted page.
// R3: next-page bit 12 shows partner can comply with the message.
// R4: next-page bit 11 holds the partner toggle bit.
// R5: next-page bits 10..0 hold code field; word read-only, resets zero.
// R6: control bit 9 set ignores the signal-detect pin.
// R7: enable bits allow sources when one; all reset to one; bit 9 far-end fault.
// R8: enables 8..5 cover transmit/receive FIFO full and empty.
// R9: enables 4, 3, 2 cover link change, remote fault, resolution failure.
// R10: enable 1 next page received, enable 0 base page received.
// R11: status bits read one while pending; a read clears them; reset zero.
// R12: status bit 9 sets on a far-end fault indication.
// R13: status bits 8..5 set when FIFOs become full or empty.
// R14: status 4 link change, 3 remote fault, 2 resolution failure.
// R15: status 1 next page received, 0 base page received.
// R16: interrupt high while any pending bit has its enable set.
module fapi_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  input  wire logic        signal_detect_pin,
  output logic             signal_detect,
  input  wire logic        far_end_fault,
  input  wire logic        tx_fifo_full,
  input  wire logic        tx_fifo_empty,
  input  wire logic        rx_fifo_full,
  input  wire logic        rx_fifo_empty,
  input  wire logic        link_up,
  input  wire logic        remote_fault_rx,
  input  wire logic        resolution_fail,
  input  wire logic        next_page_rx,
  input  wire logic        base_page_rx,
  input  wire logic [15:0] partner_page_word
);
  import fapi_pkg::*;

  fapi_state_t            q;
  fapi_state_t            next_q;
  logic                   sd_sync;
  logic [5:0]             lvl;
  logic [5:0]             rise;
  logic                   link_chg;
  logic [`FAPI_NSRC-1:0]  ev;
  logic [`FAPI_NSRC-1:0]  clr;
  logic [15:0]            rd_val;
  logic                   accept;

  //////////////////////////////////////////////////////////////////////////////
  // signal-detect pin comes from outside the clock domain
  fapi_sync u_sd_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (signal_detect_pin),
    .sync_out (sd_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // event detection; armed blocks a false edge in the first cycle after reset
  always_comb begin
    lvl      = {far_end_fault, tx_fifo_full, tx_fifo_empty,
                rx_fifo_full, rx_fifo_empty, link_up};
    rise     = lvl & ~q.lvl_prev & {6{q.armed}};
    link_chg = (link_up ^ q.lvl_prev[0]) & q.armed;
    ev                    = '0;
    ev[`FAPI_BIT_FEF]     = rise[5];          // R12
    ev[`FAPI_BIT_TXFULL]  = rise[4];          // R13
    ev[`FAPI_BIT_TXEMPTY] = rise[3];          // R13
    ev[`FAPI_BIT_RXFULL]  = rise[2];          // R13
    ev[`FAPI_BIT_RXEMPTY] = rise[1];          // R13
    ev[`FAPI_BIT_LINK]    = link_chg;         // R14
    ev[`FAPI_BIT_RFAULT]  = remote_fault_rx;  // R14
    ev[`FAPI_BIT_RESFAIL] = resolution_fail;  // R14
    ev[`FAPI_BIT_NPRX]    = next_page_rx;     // R15
    ev[`FAPI_BIT_BPRX]    = base_page_rx;     // R15
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux over current state
  always_comb begin
    rd_val = 16'h0000;
    if (q.op_hit) begin
      case (q.op_idx)
        `FAPI_IDX_LPNP:    rd_val = q.np_word;                    // R5
        `FAPI_IDX_CTRL0:   rd_val = 16'(q.bypass) << `FAPI_CTRL0_BYPASS_BIT;
        `FAPI_IDX_INT_EN:  rd_val = {6'h00, q.irq_en};
        `FAPI_IDX_INT_STS: rd_val = {6'h00, q.pend};              // R11
        default:           rd_val = 16'h0000;
      endcase
    end
  end

  assign accept = hsel && hready && htrans[1] && !q.busy;

  //////////////////////////////////////////////////////////////////////////////
  // next state; every transfer takes one wait state, so a read never races
  // the write just before it
  always_comb begin
    next_q          = q;
    clr             = '0;
    next_q.resp     = `FAPI_HRESP_OKAY;
    next_q.lvl_prev = lvl;
    next_q.armed    = 1'h1;
    if (next_page_rx) begin
      next_q.np_word = partner_page_word;                         // R1 R2 R3 R4 R5
    end
    if (q.busy) begin
      next_q.busy  = 1'h0;
      next_q.ready = 1'h1;
      if (q.op_write && q.op_hit) begin
        case (q.op_idx)
          `FAPI_IDX_CTRL0:   next_q.bypass = hwdata[`FAPI_CTRL0_BYPASS_BIT];
          `FAPI_IDX_INT_EN:  next_q.irq_en = hwdata[`FAPI_NSRC-1:0];  // R7
          `FAPI_IDX_INT_STS: clr = hwdata[`FAPI_NSRC-1:0];
          default:           clr = '0;
        endcase
      end
      if (q.op_read) begin
        next_q.rdata = {16'h0000, rd_val};
        if (q.op_hit && q.op_idx == `FAPI_IDX_INT_STS) begin
          clr = '1;                                               // R11
        end
      end
    end else if (accept) begin
      next_q.busy     = 1'h1;
      next_q.ready    = 1'h0;
      next_q.op_write = hwrite;
      next_q.op_read  = !hwrite;
      next_q.op_idx   = haddr[13:2];
      next_q.op_hit   = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0)
                        && (hsize == `FAPI_HSIZE_WORD);
    end
    // a new event wins over a clear in the same cycle
    next_q.pend    = (q.pend & ~clr) | ev;                        // R11 R12 R13 R14 R15
    next_q.irq     = |(next_q.pend & next_q.irq_en);              // R7 R8 R9 R10 R16
    // bypass treats the link as detected regardless of the pin
    next_q.sig_det = q.bypass ? 1'h1 : sd_sync;                   // R6
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q        <= '0;
      q.irq_en <= `FAPI_RST_INT_EN_FLD;                            // R7
      q.ready  <= 1'h1;
    end else begin
      q <= next_q;
    end
  end

  assign hreadyout     = q.ready;
  assign hresp         = q.resp;
  assign hrdata        = q.rdata;
  assign irq           = q.irq;
  assign signal_detect = q.sig_det;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_np_strobe;
    next_page_rx;
  endsequence

  property p_np_more;
    s_np_strobe |=> q.np_word[`FAPI_NP_MORE_BIT] == $past(partner_page_word[15]);
  endproperty
  a_np_more: assert property (p_np_more) else $error("more-pages bit not captured"); // R1

  property p_np_msg;
    s_np_strobe |=> q.np_word[`FAPI_NP_MSG_BIT] == $past(partner_page_word[13]);
  endproperty
  a_np_msg: assert property (p_np_msg) else $error("message-page bit not captured"); // R2

  property p_np_comply;
    s_np_strobe |=> q.np_word[`FAPI_NP_COMPLY_BIT] == $past(partner_page_word[12]);
  endproperty
  a_np_comply: assert property (p_np_comply) else $error("comply bit not captured"); // R3

  property p_np_toggle;
    s_np_strobe |=> q.np_word[`FAPI_NP_TOGGLE_BIT] == $past(partner_page_word[11]);
  endproperty
  a_np_toggle: assert property (p_np_toggle) else $error("toggle bit not captured"); // R4

  property p_np_hold;
    !next_page_rx |=> $stable(q.np_word);
  endproperty
  a_np_hold: assert property (p_np_hold) else $error("next-page word changed"); // R5

  property p_sd_bypass;
    q.bypass |=> signal_detect;
  endproperty
  a_sd_bypass: assert property (p_sd_bypass) else $error("bypass did not force detect"); // R6

  sequence s_wr_en;
    q.busy && q.op_write && q.op_hit && q.op_idx == `FAPI_IDX_INT_EN;
  endsequence

  property p_en_write;
    s_wr_en |=> q.irq_en == $past(hwdata[`FAPI_NSRC-1:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost"); // R7

  property p_en_block;
    q.irq_en == '0 |-> !irq;
  endproperty
  a_en_block: assert property (p_en_block) else $error("irq with all sources off"); // R8

  sequence s_rd_sts;
    q.busy && q.op_read && q.op_hit && q.op_idx == `FAPI_IDX_INT_STS;
  endsequence

  property p_rd_clear;
    s_rd_sts |=> (q.pend & ~$past(ev)) == '0 && hreadyout
                 && hrdata[`FAPI_NSRC-1:0] == $past(q.pend);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear"); // R11

  sequence s_accept;
    accept;
  endsequence

  property p_bus_wait;
    s_accept |=> !hreadyout ##1 hreadyout && hresp == `FAPI_HRESP_OKAY;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer timing wrong"); // R11

  property p_fef_set;
    q.armed && far_end_fault && !q.lvl_prev[5] |=> q.pend[`FAPI_BIT_FEF];
  endproperty
  a_fef_set: assert property (p_fef_set) else $error("far-end fault not pending"); // R12

  property p_rxe_set;
    q.armed && rx_fifo_empty && !q.lvl_prev[1] |=> q.pend[`FAPI_BIT_RXEMPTY];
  endproperty
  a_rxe_set: assert property (p_rxe_set) else $error("rx empty not pending"); // R13

  property p_link_set;
    q.armed && (link_up != q.lvl_prev[0]) |=> q.pend[`FAPI_BIT_LINK];
  endproperty
  a_link_set: assert property (p_link_set) else $error("link change not pending"); // R14

  property p_bp_set;
    base_page_rx |=> q.pend[`FAPI_BIT_BPRX] ##1 (q.pend[`FAPI_BIT_BPRX] || $past(clr[0]));
  endproperty
  a_bp_set: assert property (p_bp_set) else $error("base page not pending"); // R15

  property p_irq_level;
    q.irq == |(q.pend & q.irq_en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq disagrees with status"); // R16

  property p_np_code;
    s_np_strobe |=> q.np_word[`FAPI_NP_CODE_MSB:`FAPI_NP_CODE_LSB]
                    == $past(partner_page_word[10:0]);
  endproperty
  a_np_code: assert property (p_np_code) else $error("code field not captured"); // R5

  property p_sd_pin;
    !q.bypass |=> signal_detect == $past(sd_sync);
  endproperty
  a_sd_pin: assert property (p_sd_pin) else $error("detect does not follow pin"); // R6

  sequence s_wr_ctrl;
    q.busy && q.op_write && q.op_hit && q.op_idx == `FAPI_IDX_CTRL0;
  endsequence

  property p_ctrl_write;
    s_wr_ctrl |=> q.bypass == $past(hwdata[`FAPI_CTRL0_BYPASS_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("bypass write lost"); // R6

  property p_txf_set;
    q.armed && tx_fifo_full && !q.lvl_prev[4] |=> q.pend[`FAPI_BIT_TXFULL];
  endproperty
  a_txf_set: assert property (p_txf_set) else $error("tx full not pending"); // R13

  property p_txe_set;
    q.armed && tx_fifo_empty && !q.lvl_prev[3] |=> q.pend[`FAPI_BIT_TXEMPTY];
  endproperty
  a_txe_set: assert property (p_txe_set) else $error("tx empty not pending"); // R13

  property p_rxf_set;
    q.armed && rx_fifo_full && !q.lvl_prev[2] |=> q.pend[`FAPI_BIT_RXFULL];
  endproperty
  a_rxf_set: assert property (p_rxf_set) else $error("rx full not pending"); // R13

  property p_rf_set;
    remote_fault_rx |=> q.pend[`FAPI_BIT_RFAULT];
  endproperty
  a_rf_set: assert property (p_rf_set) else $error("remote fault not pending"); // R14

  property p_res_set;
    resolution_fail |=> q.pend[`FAPI_BIT_RESFAIL];
  endproperty
  a_res_set: assert property (p_res_set) else $error("resolution fail not pending"); // R14

  property p_np_set;
    next_page_rx |=> q.pend[`FAPI_BIT_NPRX];
  endproperty
  a_np_set: assert property (p_np_set) else $error("next page not pending"); // R15

  sequence s_wr_sts;
    q.busy && q.op_write && q.op_hit && q.op_idx == `FAPI_IDX_INT_STS;
  endsequence

  property p_wr_clear;
    s_wr_sts |=> (q.pend & $past(hwdata[`FAPI_NSRC-1:0]) & ~$past(ev)) == '0;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write-one clear failed"); // R11

  // an event in the clearing cycle must survive the read
  property p_set_wins;
    s_rd_sts |=> q.pend == $past(ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to a clear"); // R11

  property p_irq_set;
    base_page_rx |=> irq || !q.irq_en[`FAPI_BIT_BPRX];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled event gave no irq"); // R16

  property p_irq_drop;
    s_rd_sts ##0 (ev == '0) |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq held after read"); // R16

  sequence s_wr_miss;
    q.busy && q.op_write && !q.op_hit;
  endsequence

  property p_wr_refused;
    s_wr_miss |=> $stable(q.irq_en) && $stable(q.bypass);
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("refused write landed"); // R7

  // levels only load their history in the first cycle after reset
  property p_reset_quiet;
    !q.armed |=> q.pend[`FAPI_BIT_FEF:`FAPI_BIT_LINK] == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("false edge after reset"); // R11

endmodule : fapi_top

`default_nettype wire

// *** bench/fapi_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// far side: partner pages plus fifo, fault and link sources
module fapi_partner (
  input  wire logic        hclk,
  output var  logic [9:0]  src,
  output var  logic [15:0] word
);
  initial begin
    src = 10'h000;
    word = 16'h0000;
  end
  // levels other than link drop a cycle later; only their rising edge may count
  task automatic fire(input int b);
    if (b == 4) src[4] <= ~src[4];
    else src[b] <= 1'h1;
    @(posedge hclk);
    if (b != 4) src[b] <= 1'h0;
  endtask : fire
  // the word is only qualified in the strobe cycle, so it is scrambled after
  task automatic page(input logic [15:0] w);
    word <= w;
    src[1] <= 1'h1;
    @(posedge hclk);
    src[1] <= 1'h0;
    word <= ~w;
  endtask : page
endmodule : fapi_partner
`default_nettype wire

// *** bench/fapi_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fapi_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module fapi_top_test;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq, sd_pin, sd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sz;
  logic [31:0] haddr, hwdata, hrdata;
  logic [9:0]  src;
  logic [15:0] word;
  int          fails = 0;
  int          n_checks = 0;

  fapi_partner u_fapi_partner (.hclk(hclk), .src(src), .word(word));
  fapi_top u_fapi_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .signal_detect_pin(sd_pin), .signal_detect(sd), .far_end_fault(src[9]),
    .tx_fifo_full(src[8]), .tx_fifo_empty(src[7]), .rx_fifo_full(src[6]),
    .rx_fifo_empty(src[5]), .link_up(src[4]), .remote_fault_rx(src[3]),
    .resolution_fail(src[2]), .next_page_rx(src[1]), .base_page_rx(src[0]),
    .partner_page_word(word));

  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////
  // single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= w;
    hsize <= sz;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 100);
    rd = hrdata;
    `CHK("hresp", 1'h0, hresp)
    if (n >= 100) begin
      fails++;
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] v;
    bus(1'h1, idx, d, v);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] v;
    bus(1'h0, idx, 32'h0, v);
    `CHK(nm, e, v)
  endtask : rd_chk

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk("enable", `FAPI_IDX_INT_EN, 32'h3FF);
    rd_chk("status", `FAPI_IDX_INT_STS, 32'h0);
    rd_chk("ctrl", `FAPI_IDX_CTRL0, 32'h0);
    rd_chk("page", `FAPI_IDX_LPNP, 32'h0);
    rd_chk("unmapped", 12'h001, 32'h0);
    `CHK("irq", 1'h0, irq)
    $display("test reset done");
  endtask : t_reset

  // one enable at a time: its neighbour's event must stay silent
  task automatic t_sources;
    int o;
    for (int b = 0; b < 10; b++) begin
      o = (b + 1) % 10;
      wr(`FAPI_IDX_INT_EN, 32'h1 << b);
      u_fapi_partner.fire(o);
      @(posedge hclk);
      `CHK("masked irq", 1'h0, irq)
      u_fapi_partner.fire(b);
      @(posedge hclk);
      `CHK("irq", 1'h1, irq)
      rd_chk("status", `FAPI_IDX_INT_STS, (32'h1 << b) | (32'h1 << o));
      `CHK("irq cleared", 1'h0, irq)
      rd_chk("status", `FAPI_IDX_INT_STS, 32'h0);
    end
    wr(`FAPI_IDX_INT_EN, 32'h3FF);
    rd_chk("enable", `FAPI_IDX_INT_EN, 32'h3FF);
    $display("test sources done");
  endtask : t_sources

  task automatic t_page;
    u_fapi_partner.page(16'hB9A5);
    rd_chk("page", `FAPI_IDX_LPNP, 32'hB9A5);
    u_fapi_partner.page(16'h025A);
    rd_chk("page", `FAPI_IDX_LPNP, 32'h025A);
    wr(`FAPI_IDX_LPNP, 32'hFFFF);
    rd_chk("page ro", `FAPI_IDX_LPNP, 32'h025A);
    rd_chk("status", `FAPI_IDX_INT_STS, 32'h2);
    $display("test page done");
  endtask : t_page

  // pin goes through a two-stage synchroniser and the detect register, so allow four edges
  task automatic t_bypass;
    wr(`FAPI_IDX_CTRL0, 32'h200);
    rd_chk("ctrl", `FAPI_IDX_CTRL0, 32'h200);
    `CHK("detect forced", 1'h1, sd)
    sd_pin <= 1'h1;
    wr(`FAPI_IDX_CTRL0, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK("detect pin", 1'h1, sd)
    sd_pin <= 1'h0;
    repeat (4) @(posedge hclk);
    `CHK("detect pin", 1'h0, sd)
    $display("test bypass done");
  endtask : t_bypass

  // write-one clear, an event racing a clearing read, refused size, all sources off
  task automatic t_clear;
    u_fapi_partner.fire(0);
    u_fapi_partner.fire(3);
    wr(`FAPI_IDX_INT_STS, 32'h1);
    rd_chk("w1c", `FAPI_IDX_INT_STS, 32'h8);
    fork
      rd_chk("status", `FAPI_IDX_INT_STS, 32'h0);
      begin
        @(posedge hclk);
        u_fapi_partner.fire(2);
      end
    join
    rd_chk("set wins", `FAPI_IDX_INT_STS, 32'h4);
    sz = 3'h0;
    wr(`FAPI_IDX_INT_EN, 32'h0);
    rd_chk("byte read", `FAPI_IDX_INT_EN, 32'h0);
    sz = 3'h2;
    rd_chk("enable", `FAPI_IDX_INT_EN, 32'h3FF);
    wr(`FAPI_IDX_INT_EN, 32'h0);
    u_fapi_partner.fire(9);
    @(posedge hclk);
    `CHK("irq all off", 1'h0, irq)
    rd_chk("status", `FAPI_IDX_INT_STS, 32'h200);
    wr(`FAPI_IDX_INT_EN, 32'h3FF);
    $display("test clear done");
  endtask : t_clear

  // a reset in mid-run must bring every register back
  task automatic t_midreset;
    wr(`FAPI_IDX_CTRL0, 32'h200);
    wr(`FAPI_IDX_INT_EN, 32'h0);
    u_fapi_partner.page(16'h1234);
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    rd_chk("enable", `FAPI_IDX_INT_EN, 32'h3FF);
    rd_chk("ctrl", `FAPI_IDX_CTRL0, 32'h0);
    rd_chk("page", `FAPI_IDX_LPNP, 32'h0);
    rd_chk("status", `FAPI_IDX_INT_STS, 32'h0);
    `CHK("detect", 1'h0, sd)
    $display("test midreset done");
  endtask : t_midreset

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    sz = 3'h2;
    hwdata = 32'h0;
    sd_pin = 1'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_sources();
    t_page();
    t_bypass();
    t_clear();
    t_midreset();
    report_and_stop();
  end
endmodule : fapi_top_test
`default_nettype wire
